/* File: rtl/adcc_readout.sv */
`timescale 1ns/100ps

module adcc_readout #(
  parameter int RES_W = adcc_pkg::RES_W,
  parameter int DEPTH = adcc_pkg::FIFO_DEPTH
) (
  input  wire logic             core_clk,
  input  wire logic             reset_n,
  input  wire logic             serial_clk,
  input  wire logic             conversion_trigger,
  input  wire logic             chain_serial_in,
  output logic                  serial_data_out,
  output logic                  serial_data_out_oe,
  output logic                  conv_start,
  output logic                  core_power_down,
  output logic                  busy_mode,
  output logic                  conversion_done,
  input  wire logic [RES_W-1:0] result_data,
  input  wire logic             result_valid,
  output logic                  result_ready
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CONVERT,
    ST_ACQUIRE
  } adcc_state_t;

  adcc_state_t state;
  adcc_state_t next_state;

  logic                       link_clear_n;
  logic [adcc_pkg::CNT_W-1:0] fall_cnt;
  logic [adcc_pkg::CNT_W-1:0] fall_gray;
  logic [adcc_pkg::SREG_W-1:0] chain_hist;

  logic                       trig_s;
  logic                       trig_d;
  logic                       sck_s;
  logic                       trig_rise;
  logic [adcc_pkg::CNT_W-1:0] gray_s;
  logic [adcc_pkg::CNT_W-1:0] cnt_now;
  logic [adcc_pkg::CNT_W-1:0] cnt_base;
  logic [RES_W-1:0]           word;

  logic [adcc_pkg::CNT_W-1:0]  bit_idx;
  logic [adcc_pkg::CNT_W-1:0]  frame_len;
  logic [adcc_pkg::SREG_W-1:0] frame_word;
  logic [adcc_pkg::CNT_W-1:0]  pick;
  logic                        tail_bit;

  adcc_stream_if #(.W(RES_W)) res_if ();

  // ==========================================================
  // Result buffer between converter core and readout
  // ==========================================================
  adcc_fifo #(
    .W     (RES_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk      (core_clk),
    .reset_n  (reset_n),
    .in_data  (result_data),
    .in_valid (result_valid),
    .in_ready (result_ready),
    .out      (res_if.src)
  );

  // ==========================================================
  // Link domain: serial clock falling edges
  // ==========================================================
  // A low trigger ends the frame even though the serial clock may stand
  // still afterwards, so it clears the link logic asynchronously.
  assign link_clear_n = reset_n & conversion_trigger;

  always_ff @(negedge serial_clk or negedge link_clear_n) begin
    if (!link_clear_n) begin
      fall_cnt  <= adcc_pkg::CNT_RST;
      fall_gray <= adcc_pkg::CNT_RST;
    end else if (fall_cnt != adcc_pkg::CNT_MAX) begin
      fall_cnt  <= fall_cnt + 1'b1;
      fall_gray <= (fall_cnt + 1'b1) ^ ((fall_cnt + 1'b1) >> 1);
    end
  end

  // History of the chain input, one bit taken per falling edge
  always_ff @(negedge serial_clk or negedge link_clear_n) begin
    if (!link_clear_n) begin
      chain_hist <= '0;
    end else begin
      chain_hist <= {chain_hist[adcc_pkg::SREG_W-2:0], chain_serial_in};
    end
  end

  // ==========================================================
  // Crossings into the core domain
  // ==========================================================
  adcc_sync #(
    .W (2)
  ) u_sync_pins (
    .clk      (core_clk),
    .reset_n  (reset_n),
    .async_in ({conversion_trigger, serial_clk}),
    .sync_out ({trig_s, sck_s})
  );

  // Gray code so a count caught mid-change is off by one at most
  adcc_sync #(
    .W (adcc_pkg::CNT_W)
  ) u_sync_cnt (
    .clk      (core_clk),
    .reset_n  (reset_n),
    .async_in (fall_gray),
    .sync_out (gray_s)
  );

  always_comb begin
    cnt_now = '0;
    cnt_now[adcc_pkg::CNT_W-1] = gray_s[adcc_pkg::CNT_W-1];
    for (int i = adcc_pkg::CNT_W - 2; i >= 0; i--) begin
      cnt_now[i] = cnt_now[i+1] ^ gray_s[i];
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      trig_d <= 1'b0;
    end else begin
      trig_d <= trig_s;
    end
  end

  assign trig_rise = trig_s & ~trig_d;

  // ==========================================================
  // Conversion sequence
  // ==========================================================
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (trig_rise) begin
          next_state = ST_CONVERT;
        end
      end
      ST_CONVERT: begin
        if (!trig_s) begin
          next_state = ST_IDLE;
        end else if (res_if.valid) begin
          next_state = ST_ACQUIRE;
        end
      end
      ST_ACQUIRE: begin
        if (!trig_s) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  assign res_if.ready = (state == ST_CONVERT) & trig_s;

  // Start pulse toward the converter core
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      conv_start <= 1'b0;
    end else begin
      conv_start <= (state == ST_IDLE) & trig_rise;
    end
  end

  // Serial clock level at the trigger rise picks the busy bit
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_mode <= 1'b0;
    end else if ((state == ST_IDLE) && trig_rise) begin
      busy_mode <= sck_s;
    end
  end

  // Whole word and edge count captured together at completion
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      word     <= adcc_pkg::WORD_RST;
      cnt_base <= adcc_pkg::CNT_RST;
    end else if ((state == ST_CONVERT) && trig_s && res_if.valid) begin
      word     <= res_if.data;
      cnt_base <= cnt_now;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      conversion_done <= 1'b0;
    end else begin
      conversion_done <= (next_state == ST_ACQUIRE);
    end
  end

  // Core is only awake while converting
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      core_power_down <= adcc_pkg::PD_RST;
    end else begin
      core_power_down <= (next_state != ST_CONVERT);
    end
  end

  // ==========================================================
  // Serial output
  // ==========================================================
  // Word, base and mode are held steady from completion until the
  // trigger falls, and the host clocks only after seeing the busy bit or after a 3000 ns wait,
  // so the link side may read them without a further crossing.
  assign bit_idx    = fall_cnt - cnt_base;
  assign frame_len  = busy_mode ? adcc_pkg::LEN_BUSY : adcc_pkg::LEN_PLAIN;
  assign frame_word = busy_mode ? {1'b1, word} : {word, 1'b0};
  assign pick       = adcc_pkg::TOP_BIT - bit_idx;
  assign tail_bit   = busy_mode ? chain_hist[adcc_pkg::SREG_W-1] : chain_hist[adcc_pkg::SREG_W-2];

  always_comb begin
    serial_data_out    = 1'b0;
    serial_data_out_oe = 1'b0;
    if (!conversion_trigger) begin
      serial_data_out_oe = ~chain_serial_in;
    end else begin
      serial_data_out_oe = 1'b1;
      if (conversion_done) begin
        if (bit_idx < frame_len) begin
          serial_data_out = frame_word[pick];
        end else begin
          serial_data_out = tail_bit;
        end
      end
    end
  end

endmodule : adcc_readout

/* File: rtl/adcc_pkg.sv */
package adcc_pkg;

  // ==========================================================
  // Result word and serial frame
  // ==========================================================
  localparam int         RES_W      = 16;
  localparam int         SREG_W     = 17;
  localparam logic [4:0] LEN_BUSY   = 5'h11;
  localparam logic [4:0] LEN_PLAIN  = 5'h10;
  localparam logic [4:0] TOP_BIT    = 5'h10;

  // ==========================================================
  // Falling-edge counter of the serial clock
  // ==========================================================
  localparam int         CNT_W      = 5;
  localparam logic [4:0] CNT_RST    = 5'h00;
  localparam logic [4:0] CNT_MAX    = 5'h1f;

  // ==========================================================
  // Result buffer and reset values
  // ==========================================================
  localparam int         FIFO_DEPTH = 32;
  localparam logic       PD_RST     = 1'b1;
  localparam logic [RES_W-1:0] WORD_RST = 16'h0000;

endpackage : adcc_pkg

/* File: rtl/adcc_stream_if.sv */
`timescale 1ns/100ps

interface adcc_stream_if #(
  parameter int W = 16
);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (
    output valid,
    output data,
    input  ready
  );

  modport snk (
    input  valid,
    input  data,
    output ready
  );
endinterface : adcc_stream_if

/* File: rtl/adcc_sync.sv */
`timescale 1ns/100ps

module adcc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] stage1;

  // The first stage feeds only the second
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule : adcc_sync

/* File: rtl/adcc_fifo.sv */
`timescale 1ns/100ps

module adcc_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 32
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  adcc_stream_if.src        out
);

  // DEPTH must be a power of two so the pointers wrap by themselves
  localparam int             AW         = $clog2(DEPTH);
  localparam logic [AW:0]    FULL_COUNT = (AW+1)'(DEPTH);
  localparam logic [AW:0]    ONE_COUNT  = (AW+1)'(1);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0]   count;
  logic          push;
  logic          load;

  assign in_ready = (count != FULL_COUNT);
  assign push     = in_valid & in_ready;
  assign load     = (count != '0) & (~out.valid | out.ready);

  // ==========================================================
  // Storage
  // ==========================================================
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (load) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= '0;
    end else if (push && !load) begin
      count <= count + ONE_COUNT;
    end else if (load && !push) begin
      count <= count - ONE_COUNT;
    end
  end

  // ==========================================================
  // Registered read port
  // ==========================================================
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      out.valid <= 1'b0;
      out.data  <= '0;
    end else if (load) begin
      out.valid <= 1'b1;
      out.data  <= mem[rd_ptr];
    end else if (out.ready) begin
      out.valid <= 1'b0;
    end
  end

endmodule : adcc_fifo

/* File: bench/adcc_readout_asserts.sv */
`timescale 1ns/100ps

// ========
// Port checks of the readout, core clock domain
// ========
module adcc_readout_asserts #(
  parameter int RES_W = 16,
  parameter int DEPTH = 32
) (
  input wire logic             core_clk,
  input wire logic             reset_n,
  input wire logic             serial_clk,
  input wire logic             conversion_trigger,
  input wire logic             chain_serial_in,
  input wire logic             serial_data_out,
  input wire logic             serial_data_out_oe,
  input wire logic             conv_start,
  input wire logic             core_power_down,
  input wire logic             busy_mode,
  input wire logic             conversion_done,
  input wire logic [RES_W-1:0] result_data,
  input wire logic             result_valid,
  input wire logic             result_ready
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  property p_idle_low;
    !conversion_trigger && !chain_serial_in |-> serial_data_out_oe && !serial_data_out;
  endproperty
  a_idle_low: assert property (p_idle_low) else $error("serial output not driven low while idle");

  property p_start;
    $rose(conversion_trigger) |-> ##[1:6] conv_start;
  endproperty
  a_start: assert property (p_start) else $error("trigger rise gave no conversion start");

  property p_one_pulse;
    conv_start |=> !conv_start;
  endproperty
  a_one_pulse: assert property (p_one_pulse) else $error("conversion start longer than one cycle");

  property p_mode;
    conv_start |=> busy_mode == serial_clk;
  endproperty
  a_mode: assert property (p_mode) else $error("mode differs from serial clock level at trigger");

  property p_wake;
    conv_start |-> ##[0:1] !core_power_down;
  endproperty
  a_wake: assert property (p_wake) else $error("core not powered for conversion");

  property p_busy_flag;
    $rose(conversion_done) && busy_mode |-> serial_data_out && serial_data_out_oe;
  endproperty
  a_busy_flag: assert property (p_busy_flag) else $error("no busy indication at completion");

  property p_pd_done;
    $rose(conversion_done) |-> core_power_down;
  endproperty
  a_pd_done: assert property (p_pd_done) else $error("core still powered after completion");

  property p_pd_convert;
    !core_power_down |-> !conversion_done;
  endproperty
  a_pd_convert: assert property (p_pd_convert) else $error("core powered outside conversion");

  property p_frame_end;
    $fell(conversion_done) |-> !$past(conversion_trigger);
  endproperty
  a_frame_end: assert property (p_frame_end) else $error("completion dropped with trigger high");

  c_busy: cover property ($rose(conversion_done) && busy_mode);
  c_plain: cover property ($rose(conversion_done) && !busy_mode);
  c_full: cover property (result_valid && !result_ready);
endmodule : adcc_readout_asserts

bind adcc_readout adcc_readout_asserts #(.RES_W(RES_W), .DEPTH(DEPTH)) u_chk (.*);

/* File: bench/adcc_host.sv */
`timescale 1ns/100ps

// ========
// Host: trigger, link clock only inside frames, upstream chain data
// ========
module adcc_host (
  output logic      serial_clk,
  output logic      conversion_trigger,
  output logic      chain_serial_in,
  input  wire logic sdo_pin
);
  initial begin
    serial_clk = 1'b0;
    conversion_trigger = 1'b0;
    chain_serial_in = 1'b0;
  end

  task automatic frame(input bit busy, input int n, input logic [31:0] chain, output logic [63:0] cap);
    int w;
    serial_clk = busy;
    #20 conversion_trigger = 1'b1;
    if (busy) begin
      for (w = 0; w < 500 && sdo_pin !== 1'b1; w++) #12;
      #250;
    end else #3000;
    chain_serial_in = chain[0];
    for (int i = 0; i < n; i++) begin
      serial_clk = 1'b1;
      #6 cap[i] = sdo_pin;
      serial_clk = 1'b0;
      #1 chain_serial_in = chain[(i + 1) % 32];
      #5;
    end
    serial_clk = busy;
    // Trigger held through readback, then the frame is closed
    #20 conversion_trigger = 1'b0;
    chain_serial_in = 1'b0;
    #400;
  endtask : frame
endmodule : adcc_host

/* File: bench/test_adc_daisy_chain_busy_readout.sv */
`timescale 1ns/100ps

`define check_eq(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin error_cnt++; \
  $display("unexpected %s expected %h seen %h", nm, ex, gt); end end

module test_adc_daisy_chain_busy_readout;
  logic        core_clk, reset_n, result_valid, sdo_last;
  logic [15:0] result_data;
  logic        result_ready, serial_data_out, serial_data_out_oe;
  logic        conv_start, core_power_down, busy_mode, conversion_done;
  wire         serial_clk, conversion_trigger, chain_serial_in, sdo_pin;
  int          error_cnt, tests_run;
  logic [31:0] lfsr_state = 32'ha0cc;
  logic [15:0] words[$];

  adcc_readout u_dut (.*);
  adcc_host    u_host (.*);

  // Released pin shows the inverse of its last value, never a stale level
  assign sdo_pin = serial_data_out_oe ? serial_data_out : ~sdo_last;
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sdo_last <= 1'b0;
    end else if (serial_data_out_oe) begin
      sdo_last <= serial_data_out;
    end
  end

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  function automatic logic model_bit(input bit bm, input int i, input logic [15:0] w, input logic [31:0] c);
    int k;
    k = bm ? i - 1 : i;
    if (bm && i == 0) return 1'b1;
    if (k < 16) return w[15 - k];
    return c[k - 16];
  endfunction : model_bit

  task automatic push(input logic [15:0] d, output bit ok);
    int w;
    @(negedge core_clk);
    result_data = d;
    result_valid = 1'b1;
    for (w = 0; w < 4 && result_ready !== 1'b1; w++) @(negedge core_clk);
    ok = (result_ready === 1'b1);
    if (ok) @(negedge core_clk);
    result_valid = 1'b0;
  endtask : push

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  initial begin
    #400000;
    error_cnt++;
    $display("watchdog expired");
    tally_and_finish();
  end

  initial begin
    logic [63:0] cap;
    logic [31:0] ch;
    bit          ok, bm;
    int          n, len;
    result_data = 16'h0000;
    result_valid = 1'b0;
    reset_n = 1'b0;
    error_cnt = 0;
    tests_run = 0;
    repeat (6) @(negedge core_clk);
    reset_n = 1'b1;
    `check_eq("conv_start", 1'b0, conv_start)
    `check_eq("power_down", 1'b1, core_power_down)
    `check_eq("idle_pin", 2'b10, {serial_data_out_oe, serial_data_out})
    $display("test reset finished");
    ok = 1'b1;
    while (ok && words.size() < 40) begin
      lfsr_state = lfsr_next(lfsr_state);
      push(lfsr_state[15:0], ok);
      if (ok) words.push_back(lfsr_state[15:0]);
    end
    // Buffer of 32 words plus its output stage
    `check_eq("fill_level", 1'b1, words.size() inside {32, 33})
    $display("test fill finished");
    n = 0;
    while (words.size() > 0) begin
      bm = !n[0];
      len = (n == 3) ? 7 : (bm ? 33 : 32);
      lfsr_state = lfsr_next(lfsr_state);
      ch = lfsr_state;
      u_host.frame(bm, len, ch, cap);
      for (int i = 0; i < len; i++) `check_eq("sdo_bit", model_bit(bm, i, words[0], ch), cap[i])
      void'(words.pop_front());
      // Frame closed 400 ns ago: mode kept, completion cleared, core asleep, pin low
      `check_eq("busy_mode", bm, busy_mode)
      `check_eq("done_cleared", 1'b0, conversion_done)
      `check_eq("power_down_after", 1'b1, core_power_down)
      `check_eq("idle_pin_after", 2'b10, {serial_data_out_oe, serial_data_out})
      if (n == 1) begin
        lfsr_state = lfsr_next(lfsr_state);
        push(lfsr_state[15:0], ok);
        `check_eq("refill", 1'b1, ok)
        if (ok) words.push_back(lfsr_state[15:0]);
      end
      n++;
    end
    $display("test frames finished");
    tally_and_finish();
  end
endmodule : test_adc_daisy_chain_busy_readout
